// ===== logic/ppc_parallel_port_control.sv
/*
    Two-port 8-bit parallel port adapter: register file behind the E-clocked
    processor bus, peripheral data lines, request inputs, second control
    lines and active-low interrupt outputs.
    Assumes every bus and peripheral pin is asynchronous to the 100 MHz
    core clock and that E runs far slower, so each phase spans many cycles.
*/
`timescale 1ns/100ps
module ppc_parallel_port_control
    import ppc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       bus_enable,
    input  wire logic       chip_select,
    input  wire logic       read_not_write,
    input  wire logic       reg_select_low,
    input  wire logic       reg_select_high,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic [7:0] port_a_pins_in,
    output logic      [7:0] port_a_pins_out,
    output logic      [7:0] port_a_pins_oe,
    input  wire logic [7:0] port_b_pins_in,
    output logic      [7:0] port_b_pins_out,
    output logic      [7:0] port_b_pins_oe,
    input  wire logic       port_a_request_in,
    input  wire logic       port_b_request_in,
    input  wire logic       port_a_control_line_in,
    output logic            port_a_control_line_out,
    output logic            port_a_control_line_oe,
    input  wire logic       port_b_control_line_in,
    output logic            port_b_control_line_out,
    output logic            port_b_control_line_oe,
    output logic            port_a_irq_n,
    output logic            port_b_irq_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    ppc_bus_type  bus_raw;
    ppc_bus_type  bus_meta_q;
    ppc_bus_type  bus_q;
    logic [7:0]   pins_meta_q [2];
    logic [7:0]   pins_q      [2];
    logic [7:0]   pins_raw    [2];

    assign bus_raw.select  = chip_select;
    assign bus_raw.read    = read_not_write;
    assign bus_raw.reg_sel = {reg_select_high, reg_select_low};
    assign bus_raw.data    = data_in;
    assign pins_raw[0]     = port_a_pins_in;
    assign pins_raw[1]     = port_b_pins_in;

    // Bus pins settle long before E falls, so two stages keep pace with E
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_meta_q <= '0;
            bus_q      <= '0;
        end else begin
            bus_meta_q <= bus_raw;
            bus_q      <= bus_meta_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pins_meta_q[0] <= PPC_REG_RESET;
            pins_meta_q[1] <= PPC_REG_RESET;
            pins_q[0]      <= PPC_REG_RESET;
            pins_q[1]      <= PPC_REG_RESET;
        end else begin
            pins_meta_q[0] <= pins_raw[0];
            pins_meta_q[1] <= pins_raw[1];
            pins_q[0]      <= pins_meta_q[0];
            pins_q[1]      <= pins_meta_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection: E, requests A/B, control lines A/B

    localparam int EDGE_COUNT = 5;

    logic [EDGE_COUNT-1:0] edge_in;
    logic [EDGE_COUNT-1:0] edge_level;
    logic [EDGE_COUNT-1:0] edge_rise;
    logic [EDGE_COUNT-1:0] edge_fall;

    assign edge_in = {port_b_control_line_in, port_a_control_line_in,
                      port_b_request_in, port_a_request_in, bus_enable};

    generate
        for (genvar i = 0; i < EDGE_COUNT; i++) begin : g_sync
            ppc_edge_sync u_sync (
                .clock    (clock),
                .rst_n    (rst_n),
                .async_in (edge_in[i]),
                .level    (edge_level[i]),
                .rise     (edge_rise[i]),
                .fall     (edge_fall[i])
            );
        end
    endgenerate

    logic e_level;
    logic e_rise;
    logic e_fall;

    assign e_level = edge_level[0];
    assign e_rise  = edge_rise[0];
    assign e_fall  = edge_fall[0];

    ////////////////////////////////////////////////////////////////////////////
    // Per-port register file and flag logic

    ppc_ctrl_type ctrl_q      [2];
    ppc_ctrl_type ctrl_d      [2];
    logic [7:0]   dir_q       [2];
    logic [7:0]   out_q       [2];
    logic [7:0]   periph_rd   [2];
    logic         irq_n_q     [2];
    logic         line_out    [2];
    logic         data_strobe [2];
    logic         req_set_w   [2];

    generate
        for (genvar p = 0; p < 2; p++) begin : g_port
            localparam logic [1:0] DATA_SEL = (p == 0) ? PPC_SEL_A_DATA : PPC_SEL_B_DATA;
            localparam logic [1:0] CTRL_SEL = (p == 0) ? PPC_SEL_A_CTRL : PPC_SEL_B_CTRL;

            logic data_hit;
            logic ctrl_wr;
            logic dir_wr;
            logic out_wr;
            logic periph_read;
            logic req_edge;
            logic line_edge;
            logic req_set;
            logic line_set;

            // Accesses take effect when E falls, as the processor sees them
            assign data_hit    = e_fall && ppc_hit(bus_q, DATA_SEL);
            assign ctrl_wr     = e_fall && ppc_hit(bus_q, CTRL_SEL) && !bus_q.read;
            assign dir_wr      = data_hit && !bus_q.read && !ctrl_q[p].data_select;
            assign out_wr      = data_hit && !bus_q.read && ctrl_q[p].data_select;
            assign periph_read = data_hit && bus_q.read && ctrl_q[p].data_select;

            // Edge choice: rising when the select bit is set, else falling
            assign req_edge  = ctrl_q[p].req_rising ? edge_rise[1 + p]
                                                    : edge_fall[1 + p];
            assign line_edge = ctrl_q[p].line_mode ? edge_rise[3 + p]
                                                   : edge_fall[3 + p];
            assign req_set   = req_edge;
            assign line_set  = line_edge && !ctrl_q[p].line_output;

            assign req_set_w[p]   = req_set;
            assign data_strobe[p] = (p == 0) ? (data_hit && bus_q.read && ctrl_q[p].data_select)
                                             : out_wr;

            // A new edge in the clearing read's cycle still leaves its flag set
            always_comb begin
                ctrl_d[p] = ctrl_q[p];
                if (ctrl_wr) begin
                    ctrl_d[p] = ppc_ctrl_type'((ctrl_q[p] & ~PPC_CTRL_WR_MASK)
                                | (bus_q.data & PPC_CTRL_WR_MASK));
                end
                if (periph_read) begin
                    ctrl_d[p].flag_req  = 1'b0;
                    ctrl_d[p].flag_line = 1'b0;
                end
                if (req_set) begin
                    ctrl_d[p].flag_req = 1'b1;
                end
                if (line_set) begin
                    ctrl_d[p].flag_line = 1'b1;
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_q[p] <= ppc_ctrl_type'(PPC_REG_RESET);
                    dir_q[p]  <= PPC_REG_RESET;
                    out_q[p]  <= PPC_REG_RESET;
                end else begin
                    ctrl_q[p] <= ctrl_d[p];
                    if (dir_wr) begin
                        dir_q[p] <= bus_q.data;
                    end
                    // Kept while lines are inputs; driven once made outputs
                    if (out_wr) begin
                        out_q[p] <= bus_q.data;
                    end
                end
            end

            // Cleared masks keep irq high whatever the flags say
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    irq_n_q[p] <= 1'b1;
                end else begin
                    irq_n_q[p] <= !((ctrl_q[p].flag_req && ctrl_q[p].req_enable)
                                 || (ctrl_q[p].flag_line && ctrl_q[p].line_enable
                                     && !ctrl_q[p].line_output));
                end
            end

            ppc_line_out #(
                .PORT_B (p == 1)
            ) u_line (
                .clock        (clock),
                .rst_n        (rst_n),
                .ctrl         (ctrl_q[p]),
                .e_rise       (e_rise),
                .e_fall       (e_fall),
                .selected     (bus_q.select),
                .data_strobe  (data_strobe[p]),
                .req_flag_set (req_set_w[p]),
                .line_q       (line_out[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral read values

    // Port A reads the pins; port B returns its own latch on output lines
    assign periph_rd[0] = pins_q[0];
    assign periph_rd[1] = (dir_q[1] & out_q[1]) | (~dir_q[1] & pins_q[1]);

    ////////////////////////////////////////////////////////////////////////////
    // Processor read path

    logic [7:0] read_val;
    logic [7:0] data_out_q;

    always_comb begin
        read_val = PPC_REG_RESET;
        case (bus_q.reg_sel)
            PPC_SEL_A_DATA: begin
                read_val = ctrl_q[0].data_select ? periph_rd[0] : dir_q[0];
            end
            PPC_SEL_A_CTRL: begin
                read_val = ctrl_q[0];
            end
            PPC_SEL_B_DATA: begin
                read_val = ctrl_q[1].data_select ? periph_rd[1] : dir_q[1];
            end
            PPC_SEL_B_CTRL: begin
                read_val = ctrl_q[1];
            end
            default: begin
                read_val = PPC_REG_RESET;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_out_q <= PPC_REG_RESET;
        end else begin
            data_out_q <= read_val;
        end
    end

    // Bus driven only while E is high on a selected read
    assign data_oe  = e_level && bus_q.select && bus_q.read;
    assign data_out = data_out_q;

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral and control-line outputs

    assign port_a_pins_out = out_q[0];
    assign port_a_pins_oe  = dir_q[0];
    assign port_b_pins_out = out_q[1];
    assign port_b_pins_oe  = dir_q[1];

    assign port_a_control_line_out = line_out[0];
    assign port_a_control_line_oe  = ctrl_q[0].line_output;
    assign port_b_control_line_out = line_out[1];
    assign port_b_control_line_oe  = ctrl_q[1].line_output;

    assign port_a_irq_n = irq_n_q[0];
    assign port_b_irq_n = irq_n_q[1];

endmodule // ppc_parallel_port_control

// ===== logic/ppc_pkg.sv
/*
    Shared constants and carrier types of the parallel port control block:
    register selects, control bit layout, reset values, timing figures.
    Assumes a 100 MHz core clock that samples the adapter's bus pins.
*/
// Summary of operation
// - Processor writes control bits 0 to 5 only; bits 6, 7 set by lines.
// - A control register read returns all eight bits, flags included.
// - Direction bit 1 drives the peripheral line; 0 leaves it an input.
// - Control bit 2 picks direction (0) or peripheral data (1) register.
// - Four selects: A data, A control, B data, B control.
// - Reset held low at least 1 us clears every register to zero.
// - After reset all four control lines are falling-edge interrupt inputs.
// - After reset all interrupts masked; flags alone never pull irq low.
// - Control bit 1 picks request edge for flag 7: 0 falling, 1 rising.
// - Control bit 0 lets flag 7 pull the port interrupt low.
// - Bit 5 low: second line is input, bit 4 edge, bit 3 enable, flag 6.
// - Bit 5 high: second line output; 00 handshake, 01 pulse, 1x bit 3.
// - Data written while line is input is kept and driven once output.
// - Port A line low on E fall after data read; pulse ends deselected.
// - Handshake: second line goes high when request sets flag 7.
// - Port B line low on E rise after data write; pulse ends later.
// - Only a peripheral data read clears flags; writes never touch them.
package ppc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [1:0] PPC_SEL_A_DATA  = 2'h0;
    localparam logic [1:0] PPC_SEL_A_CTRL  = 2'h1;
    localparam logic [1:0] PPC_SEL_B_DATA  = 2'h2;
    localparam logic [1:0] PPC_SEL_B_CTRL  = 2'h3;

    localparam logic [7:0] PPC_REG_RESET   = 8'h00;
    localparam logic [7:0] PPC_CTRL_WR_MASK = 8'h3F;
    localparam logic [1:0] PPC_MODE_HANDSHAKE = 2'h0;
    localparam logic [1:0] PPC_MODE_PULSE     = 2'h1;

    localparam int PPC_CLK_PERIOD_NS    = 10;
    localparam int PPC_RESET_MIN_NS     = 1000;
    localparam int PPC_RESET_MIN_CYCLES =
        (PPC_RESET_MIN_NS + PPC_CLK_PERIOD_NS - 1) / PPC_CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       select;
        logic       read;
        logic [1:0] reg_sel;
        logic [7:0] data;
    } ppc_bus_type;

    typedef struct packed {
        logic flag_req;
        logic flag_line;
        logic line_output;
        logic line_mode;
        logic line_enable;
        logic data_select;
        logic req_rising;
        logic req_enable;
    } ppc_ctrl_type;

    function automatic logic ppc_hit(input ppc_bus_type bus, input logic [1:0] sel);
        return bus.select && (bus.reg_sel == sel);
    endfunction

endpackage

// ===== logic/ppc_edge_sync.sv
/*
    Two-stage synchroniser for one asynchronous pin with rise and fall pulses.
    Assumes a single core clock; pulses last one clock cycle.
*/
`timescale 1ns/100ps
module ppc_edge_sync
    import ppc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Edge logic looks at the second stage only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;
endmodule // ppc_edge_sync

// ===== logic/ppc_line_out.sv
/*
    Output behaviour of one port's second control line: handshake, pulse
    and follow-bit-3 modes. Assumes E edges arrive as one-cycle pulses.
*/
`timescale 1ns/100ps
module ppc_line_out
    import ppc_pkg::*;
#(
    parameter bit PORT_B = 1'b0
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire ppc_ctrl_type ctrl,
    input  wire logic         e_rise,
    input  wire logic         e_fall,
    input  wire logic         selected,
    input  wire logic         data_strobe,
    input  wire logic         req_flag_set,
    output logic              line_q
);
    logic       pend_q;
    logic       desel_q;
    logic [1:0] mode;
    logic       hs_or_pulse;
    logic       pulse;

    assign mode        = {ctrl.line_mode, ctrl.line_enable};
    assign pulse       = ctrl.line_output && (mode == PPC_MODE_PULSE);
    assign hs_or_pulse = ctrl.line_output && !ctrl.line_mode;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            line_q  <= 1'b0;
            pend_q  <= 1'b0;
            desel_q <= 1'b0;
        end else begin
            if (e_fall) begin
                desel_q <= ~selected;
            end
            if (ctrl.line_output && ctrl.line_mode) begin
                line_q <= ctrl.line_enable;
            end else if (PORT_B) begin
                if (e_fall && data_strobe && hs_or_pulse) begin
                    pend_q <= 1'b1;
                end else if (e_rise && pend_q) begin
                    pend_q <= 1'b0;
                    line_q <= 1'b0;
                end else if (e_rise && pulse && desel_q) begin
                    line_q <= 1'b1;
                end else if (req_flag_set && ctrl.line_output && mode == 2'h0) begin
                    line_q <= 1'b1;
                end
            end else begin
                if (e_fall && data_strobe && hs_or_pulse) begin
                    line_q <= 1'b0;
                end else if (e_fall && pulse && !selected) begin
                    line_q <= 1'b1;
                end else if (req_flag_set && ctrl.line_output && mode == 2'h0) begin
                    line_q <= 1'b1;
                end
            end
        end
    end
endmodule // ppc_line_out

// ===== verif/ppc_chk.sv
/*
    Port-level checker of the parallel port control block.
    Assumes bind from the testbench top; sees top module ports only.
*/
`timescale 1ns/100ps
module ppc_chk (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       bus_enable,
    input wire logic       chip_select,
    input wire logic       read_not_write,
    input wire logic       reg_select_low,
    input wire logic       reg_select_high,
    input wire logic       data_oe,
    input wire logic [7:0] port_a_pins_oe,
    input wire logic [7:0] port_b_pins_oe,
    input wire logic       port_a_control_line_oe,
    input wire logic       port_b_control_line_oe,
    input wire logic       port_a_irq_n,
    input wire logic       port_b_irq_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    property p_reset_state;
        $rose(rst_n) |-> port_a_irq_n && port_b_irq_n && !data_oe && port_a_pins_oe == 8'h00
            && port_b_pins_oe == 8'h00 && !port_a_control_line_oe && !port_b_control_line_oe;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    property p_oe_read;
        // Pins reach data_oe through two synchroniser flops
        data_oe |-> $past(chip_select, 2) && $past(read_not_write, 2);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("bus driven outside a read");
    property p_oe_strobe;
        data_oe |-> $past(bus_enable, 2);
    endproperty
    a_oe_strobe: assert property (p_oe_strobe) else $error("bus driven with E low");
    property p_line_a;
        $changed(port_a_control_line_oe) |-> $past(chip_select, 3) && !$past(read_not_write, 3)
            && $past(reg_select_low, 3) && !$past(reg_select_high, 3);
    endproperty
    a_line_a: assert property (p_line_a) else $error("A line mode without A control write");
    property p_line_b;
        $changed(port_b_control_line_oe) |-> $past(chip_select, 3) && !$past(read_not_write, 3)
            && $past(reg_select_low, 3) && $past(reg_select_high, 3);
    endproperty
    a_line_b: assert property (p_line_b) else $error("B line mode without B control write");
    property p_dir_a;
        $changed(port_a_pins_oe) |-> $past(chip_select, 3) && !$past(read_not_write, 3)
            && !$past(reg_select_low, 3) && !$past(reg_select_high, 3);
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("A direction without A data write");
    property p_dir_b;
        $changed(port_b_pins_oe) |-> $past(chip_select, 3) && !$past(read_not_write, 3)
            && !$past(reg_select_low, 3) && $past(reg_select_high, 3);
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("B direction without B data write");
    property p_irq_a;
        $rose(port_a_irq_n) |-> $past(chip_select, 4) && !$past(reg_select_high, 4);
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("A interrupt released by itself");
    property p_irq_b;
        $rose(port_b_irq_n) |-> $past(chip_select, 4) && $past(reg_select_high, 4);
    endproperty
    a_irq_b: assert property (p_irq_b) else $error("B interrupt released by itself");
endmodule // ppc_chk

// ===== verif/ppc_periph.sv
/*
    Peripheral beside one port: own data byte and second line level.
    Assumes the bench sets its own levels; adapter-driven bits win.
*/
`timescale 1ns/100ps
module ppc_periph (
    input wire logic [7:0] own_val,
    input wire logic [7:0] pins_out,
    input wire logic [7:0] pins_oe,
    input wire logic       line_drv,
    input wire logic       line_out,
    input wire logic       line_oe,
    output logic     [7:0] pins_in,
    output logic           line_in
);
    // Each wire resolved from both parties so the adapter sees a real level
    assign pins_in = (pins_out & pins_oe) | (own_val & ~pins_oe);
    assign line_in = line_oe ? line_out : line_drv;
endmodule // ppc_periph

// ===== verif/testbench.sv
/*
    Self-checking bench of the parallel port control block with a model
    of registers and flags. Assumes E phases of six core cycles.
*/
`timescale 1ns/100ps
module testbench;
    import ppc_pkg::*;
    logic       clock = 1'b0, rst_n = 1'b0, bus_enable = 1'b0, chip_select = 1'b0;
    logic       read_not_write = 1'b1, reg_select_low = 1'b0, reg_select_high = 1'b0;
    logic [7:0] data_in = 8'h00, data_out, pa_out, pa_oe, pb_out, pb_oe, pa_in, pb_in;
    logic [7:0] pv [2];
    logic       req [2], cli [2];
    logic       la_out, la_oe, lb_out, lb_oe, la_in, lb_in, data_oe, irq_a_n, irq_b_n;
    int         miscompares = 0, tests_run = 0, seed = 32'h379faadb;
    int         ctl [2], dir [2], lat [2];
    logic [7:0] r;
    always #5 clock = ~clock;
    initial begin
        pv[0] = 8'h00; pv[1] = 8'h00; req[0] = 1'b0; req[1] = 1'b0; cli[0] = 1'b0; cli[1] = 1'b0;
    end
    ppc_parallel_port_control dut (.clock(clock), .rst_n(rst_n), .bus_enable(bus_enable),
        .chip_select(chip_select), .read_not_write(read_not_write),
        .reg_select_low(reg_select_low), .reg_select_high(reg_select_high), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .port_a_pins_in(pa_in), .port_a_pins_out(pa_out),
        .port_a_pins_oe(pa_oe), .port_b_pins_in(pb_in), .port_b_pins_out(pb_out),
        .port_b_pins_oe(pb_oe), .port_a_request_in(req[0]), .port_b_request_in(req[1]),
        .port_a_control_line_in(la_in), .port_a_control_line_out(la_out),
        .port_a_control_line_oe(la_oe), .port_b_control_line_in(lb_in),
        .port_b_control_line_out(lb_out), .port_b_control_line_oe(lb_oe),
        .port_a_irq_n(irq_a_n), .port_b_irq_n(irq_b_n));
    ppc_periph peri_a (.own_val(pv[0]), .pins_out(pa_out), .pins_oe(pa_oe), .line_drv(cli[0]),
        .line_out(la_out), .line_oe(la_oe), .pins_in(pa_in), .line_in(la_in));
    ppc_periph peri_b (.own_val(pv[1]), .pins_out(pb_out), .pins_oe(pb_oe), .line_drv(cli[1]),
        .line_out(lb_out), .line_oe(lb_oe), .pins_in(pb_in), .line_in(lb_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic rw, input int p, input logic c, input logic [7:0] wd);
        @(posedge clock);
        chip_select <= 1'b1; read_not_write <= rw; data_in <= wd;
        reg_select_high <= p[0]; reg_select_low <= c;
        repeat (6) @(posedge clock);
        bus_enable <= 1'b1;
        repeat (6) @(posedge clock);
        r = data_out;
        if (rw) check({7'h00, data_oe}, 8'h01);
        bus_enable <= 1'b0;
        repeat (6) @(posedge clock);
        chip_select <= 1'b0; read_not_write <= 1'b1;
        repeat (2) @(posedge clock);
    endtask
    task automatic wr(input int p, input logic c, input logic [7:0] v);
        bus(1'b0, p, c, v);
        if (c) ctl[p] = (ctl[p] & 'hC0) | (v & 'h3F);
        else if (ctl[p][2]) lat[p] = v;
        else dir[p] = v;
    endtask
    task automatic rd(input int p, input logic c);
        bus(1'b1, p, c, 8'h00);
        if (c) check(r, 8'(ctl[p]));
        else if (!ctl[p][2]) check(r, 8'(dir[p]));
        else begin
            check(r, 8'((lat[p] & dir[p]) | (pv[p] & ~dir[p])));
            ctl[p] = ctl[p] & 'h3F;
        end
    endtask
    task automatic e_idle();
        repeat (6) @(posedge clock) bus_enable <= 1'b1;
        repeat (6) @(posedge clock) bus_enable <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        for (int p = 0; p < 2; p++) begin
            rd(p, 1);
            rd(p, 0);
            pv[p] <= 8'($random(seed));
            wr(p, 1, 8'hFF);
            rd(p, 1);
            wr(p, 1, 8'h00);
        end
        wr(0, 0, 8'($random(seed)));
        wr(0, 1, 8'h04);
        wr(0, 0, 8'($random(seed)));
        check(pa_oe, 8'(dir[0]));
        rd(0, 0);
        wr(1, 1, 8'h04);
        wr(1, 0, 8'($random(seed)));
        wr(1, 1, 8'h00);
        wr(1, 0, 8'hFF);
        check(pb_out, 8'(lat[1]));
        check(pb_oe, 8'hFF);
        wr(1, 1, 8'h04);
        rd(1, 0);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                wr(p, 1, 8'({k[1], k[0], 1'b1, k[1], k[0]}));
                req[p] <= !k[1]; cli[p] <= !k[1];
                repeat (8) @(posedge clock);
                rd(p, 0);
                req[p] <= k[1]; cli[p] <= k[1];
                repeat (8) @(posedge clock);
                ctl[p] = ctl[p] | 'hC0;
                check({7'h00, p ? irq_b_n : irq_a_n}, {7'h00, !k[0]});
                rd(p, 1);
                wr(p, 0, 8'($random(seed)));
                rd(p, 1);
                rd(p, 0);
                check({7'h00, p ? irq_b_n : irq_a_n}, 8'h01);
                req[p] <= !k[1]; cli[p] <= !k[1];
                repeat (8) @(posedge clock);
                rd(p, 1);
            end
            for (int b = 0; b < 2; b++) begin
                wr(p, 1, 8'(8'h34 | (b << 3)));
                check({6'h00, p ? {lb_oe, lb_out} : {la_oe, la_out}}, 8'(2 + b));
            end
        end
        req[0] <= 1'b1; req[1] <= 1'b1;
        wr(0, 1, 8'h24);
        rd(0, 0);
        check({7'h00, la_out}, 8'h00);
        req[0] <= 1'b0;
        repeat (8) @(posedge clock);
        check({7'h00, la_out}, 8'h01);
        ctl[0] = ctl[0] | 'h80;
        wr(0, 1, 8'h2C);
        rd(0, 0);
        check({7'h00, la_out}, 8'h00);
        e_idle();
        check({7'h00, la_out}, 8'h01);
        wr(1, 1, 8'h24);
        wr(1, 0, 8'($random(seed)));
        e_idle();
        check({7'h00, lb_out}, 8'h00);
        req[1] <= 1'b0;
        repeat (8) @(posedge clock);
        check({7'h00, lb_out}, 8'h01);
        wr(1, 1, 8'h2C);
        wr(1, 0, 8'($random(seed)));
        e_idle();
        check({7'h00, lb_out}, 8'h00);
        e_idle();
        check({7'h00, lb_out}, 8'h01);
        complete_run();
    end
endmodule // testbench
bind ppc_parallel_port_control ppc_chk u_chk (.clock(clock), .rst_n(rst_n),
    .bus_enable(bus_enable), .chip_select(chip_select), .read_not_write(read_not_write),
    .reg_select_low(reg_select_low), .reg_select_high(reg_select_high), .data_oe(data_oe),
    .port_a_pins_oe(port_a_pins_oe), .port_b_pins_oe(port_b_pins_oe),
    .port_a_control_line_oe(port_a_control_line_oe),
    .port_b_control_line_oe(port_b_control_line_oe),
    .port_a_irq_n(port_a_irq_n), .port_b_irq_n(port_b_irq_n));
